// ---- hw/tsf_pkg.sv ----
// Constants for the timer status flag block
package tsf_pkg;
   // Register map, byte addresses on the 12-bit register port
   localparam logic [11:0] TSF_ADDR_STATUS = 12'hF23;
   localparam logic [11:0] TSF_ADDR_CLEAR  = 12'hF2C;
   localparam logic [11:0] TSF_ADDR_ENABLE = 12'hF2D;
   localparam logic [11:0] TSF_ADDR_CTRL   = 12'hF2E;

   // Status and control field positions
   localparam int TSF_BIT_CH0_EVT  = 0;
   localparam int TSF_BIT_CH1_EVT  = 1;
   localparam int TSF_BIT_RELOAD   = 3;
   localparam int TSF_BIT_CH0_OVR  = 4;
   localparam int TSF_BIT_CH1_OVR  = 5;
   localparam int TSF_BIT_NOISE    = 7;
   localparam int TSF_BIT_NF_EN    = 7;
   localparam int TSF_OVR_OFFSET   = 4;
   localparam int TSF_CHANNELS     = 2;

   localparam logic [7:0] TSF_STATUS_RESET = 8'h00;
   localparam logic [7:0] TSF_VALID_MASK   = 8'hBB;
   localparam logic [7:0] TSF_CTRL_MASK    = 8'h80;
   localparam logic [7:0] TSF_ZERO_BYTE    = 8'h00;

   // Noise filter window: odd so the majority vote never ties
   localparam int TSF_NF_SAMPLES = 5;
   localparam int TSF_NF_CNT_W   = 3;
endpackage

// ---- hw/tsf_nf_if.sv ----
// Link between the status block and its noise detector
`timescale 1ns/10ps
interface tsf_nf_if;
   logic pin_level;
   logic centre;
   logic filtered;
   logic noise;
   modport top (output pin_level, output centre, input filtered, input noise);
   modport det (input pin_level, input centre, output filtered, output noise);
endinterface

// ---- hw/tsf_noise_det.sv ----
// Majority-vote sampler that reports noise at the bit centre
`timescale 1ns/10ps
module tsf_noise_det
   import tsf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Filter side
   tsf_nf_if.det    nf
);
   logic [TSF_NF_SAMPLES-1:0] win_r;
   logic [TSF_NF_CNT_W-1:0]   ones;
   logic                      avg;
   logic                      filtered_r;
   logic                      noise_r;

   always_comb begin
      ones = '0;
      for (int i = 0; i < TSF_NF_SAMPLES; i++) begin
         ones = ones + TSF_NF_CNT_W'(win_r[i]);
      end
      avg = (ones > TSF_NF_CNT_W'(TSF_NF_SAMPLES / 2));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         win_r <= '0;
      end else begin
         win_r <= {win_r[TSF_NF_SAMPLES-2:0], nf.pin_level};
      end
   end

   // Filtered value passes on at each bit centre, noise or not
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         filtered_r <= 1'b0;
      end else if (nf.centre) begin
         filtered_r <= avg;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         noise_r <= 1'b0;
      end else begin
         noise_r <= nf.centre && (win_r != {TSF_NF_SAMPLES{avg}});
      end
   end

   assign nf.filtered = filtered_r;
   assign nf.noise    = noise_r;

   chk_noise_mismatch : assert property (@(posedge clk) disable iff (!rst_n)
      nf.centre && (win_r != {TSF_NF_SAMPLES{avg}}) |=> nf.noise)
      else $error("noise not flagged on sample mismatch");

   chk_noise_centre_only : assert property (@(posedge clk) disable iff (!rst_n)
      !nf.centre |=> !nf.noise)
      else $error("noise reported away from bit centre");

   chk_filtered_pass : assert property (@(posedge clk) disable iff (!rst_n)
      nf.centre |=> nf.filtered == $past(avg))
      else $error("filtered value not passed at bit centre");
endmodule

// ---- hw/tsf_status.sv ----
// Timer event status flags with register port and interrupt
`timescale 1ns/10ps
module tsf_status
   import tsf_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Register port
   input  wire logic [11:0] addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [7:0]       rdata,
   // Timer events, timer clock domain
   input  wire logic [1:0]  chan_event,
   input  wire logic        reload_event,
   input  wire logic        bit_centre,
   // Timer input pin
   input  wire logic        timer_input_pin,
   // Outputs to the timer
   output logic             filtered_input,
   output logic             irq
);
   logic                    rst_n_m_r;
   logic                    rst_n_r;
   logic [2:0]              pin_sync_r;
   logic                    pin_stable_r;
   logic [7:0]              stat_r;
   logic [7:0]              stat_nxt;
   logic [7:0]              enable_r;
   logic                    nf_en_r;
   logic [7:0]              rdata_r;
   logic                    irq_r;
   logic                    filtered_r;
   logic [7:0]              clr;
   logic                    noise_set;
   logic [TSF_CHANNELS-1:0] stat_nxt_ch;
   logic [TSF_CHANNELS-1:0] ovr_nxt_ch;

   tsf_nf_if nf_link ();

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n_r);

   // Reset release through two flops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_n_m_r <= 1'b0;
         rst_n_r   <= 1'b0;
      end else begin
         rst_n_m_r <= 1'b1;
         rst_n_r   <= rst_n_m_r;
      end
   end

   // Pin sync; a level counts once stages two and three agree
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pin_sync_r   <= '0;
         pin_stable_r <= 1'b0;
      end else begin
         pin_sync_r <= {pin_sync_r[1:0], timer_input_pin};
         if (pin_sync_r[1] == pin_sync_r[2]) begin
            pin_stable_r <= pin_sync_r[2];
         end
      end
   end

   assign nf_link.pin_level = pin_stable_r;
   assign nf_link.centre    = bit_centre;

   tsf_noise_det u_noise_det (
      .clk   (clk),
      .rst_n (rst_n_r),
      .nf    (nf_link.det)
   );

   // Both the status address and the clear alias take write-one-to-clear
   always_comb begin
      clr = TSF_ZERO_BYTE;
      if (wr && (addr == TSF_ADDR_STATUS || addr == TSF_ADDR_CLEAR)) begin
         clr = wdata & TSF_VALID_MASK;
      end
   end

   assign noise_set = nf_link.noise && nf_en_r;

   // Flag next state; a set in the clear cycle wins
   always_comb begin
      stat_nxt = stat_r & TSF_VALID_MASK;
      stat_nxt[TSF_BIT_RELOAD] = reload_event
                                 || (stat_r[TSF_BIT_RELOAD] && !clr[TSF_BIT_RELOAD]);
      stat_nxt[TSF_BIT_NOISE]  = noise_set
                                 || (stat_r[TSF_BIT_NOISE] && !clr[TSF_BIT_NOISE]);
      for (int ch = 0; ch < TSF_CHANNELS; ch++) begin
         stat_nxt[TSF_BIT_CH0_EVT + ch] = stat_nxt_ch[ch];
         stat_nxt[TSF_OVR_OFFSET + ch]  = ovr_nxt_ch[ch];
      end
   end

   generate
      for (genvar ch = 0; ch < TSF_CHANNELS; ch++) begin : g_chan
         logic evt_set;
         logic ovr_set;
         // Event sets the flag with no interrupt-enable gating
         assign evt_set = chan_event[ch];
         // Overrun only if the old event was not being cleared now
         assign ovr_set = chan_event[ch] && stat_r[ch] && !clr[ch];
         assign stat_nxt_ch[ch] = evt_set || (stat_r[ch] && !clr[ch]);
         assign ovr_nxt_ch[ch]  = ovr_set || (stat_r[ch + TSF_OVR_OFFSET] && !clr[ch]);

         chk_chan_set : assert property (@(posedge clk) disable iff (!rst_n_r)
            chan_event[ch] |=> stat_r[ch])
            else $error("channel event flag not set");

         chk_chan_clear : assert property (@(posedge clk) disable iff (!rst_n_r)
            clr[ch] && !chan_event[ch] |=> !stat_r[ch] && !stat_r[ch + TSF_OVR_OFFSET])
            else $error("channel flag clear failed");

         chk_ovr_set : assert property (@(posedge clk) disable iff (!rst_n_r)
            chan_event[ch] && stat_r[ch] && !clr[ch] |=> stat_r[ch + TSF_OVR_OFFSET])
            else $error("overrun not flagged");
      end
   endgenerate

   // Reserved bits never store
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         stat_r <= TSF_STATUS_RESET;
      end else begin
         stat_r <= stat_nxt & TSF_VALID_MASK;
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         enable_r <= TSF_ZERO_BYTE;
      end else if (wr && addr == TSF_ADDR_ENABLE) begin
         enable_r <= wdata & TSF_VALID_MASK;
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         nf_en_r <= 1'b0;
      end else if (wr && addr == TSF_ADDR_CTRL) begin
         nf_en_r <= wdata[TSF_BIT_NF_EN];
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rdata_r <= TSF_ZERO_BYTE;
      end else if (rd) begin
         case (addr)
            TSF_ADDR_STATUS: rdata_r <= stat_r & TSF_VALID_MASK;
            TSF_ADDR_ENABLE: rdata_r <= enable_r;
            TSF_ADDR_CTRL:   rdata_r <= nf_en_r ? TSF_CTRL_MASK : TSF_ZERO_BYTE;
            default:         rdata_r <= TSF_ZERO_BYTE;
         endcase
      end else begin
         rdata_r <= TSF_ZERO_BYTE;
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(stat_r & enable_r);
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         filtered_r <= 1'b0;
      end else begin
         filtered_r <= nf_link.filtered;
      end
   end

   assign rdata          = rdata_r;
   assign irq            = irq_r;
   assign filtered_input = filtered_r;

   sequence s_status_read;
      rd && addr == TSF_ADDR_STATUS;
   endsequence

   sequence s_flags_seen;
      rdata == ($past(stat_r) & TSF_VALID_MASK);
   endsequence

   chk_status_read : assert property (s_status_read |=> s_flags_seen)
      else $error("status read data wrong");

   chk_reserved_zero : assert property ((stat_r & ~TSF_VALID_MASK) == TSF_ZERO_BYTE)
      else $error("reserved status bit set");

   chk_rdata_idle : assert property (!rd |=> rdata == TSF_ZERO_BYTE)
      else $error("read data left standing");

   chk_noise_gate : assert property (
      !nf_en_r && !stat_r[TSF_BIT_NOISE] |=> !stat_r[TSF_BIT_NOISE])
      else $error("noise flag set with filter off");

   chk_noise_set : assert property (nf_link.noise && nf_en_r |=> stat_r[TSF_BIT_NOISE])
      else $error("noise flag not set");

   chk_reload_set : assert property (reload_event |=> stat_r[TSF_BIT_RELOAD])
      else $error("reload flag not set");

   chk_reload_clear : assert property (
      clr[TSF_BIT_RELOAD] && !reload_event |=> !stat_r[TSF_BIT_RELOAD])
      else $error("reload flag clear failed");

   chk_filtered_out : assert property (filtered_input == $past(nf_link.filtered))
      else $error("filtered value not passed out");

   chk_irq_level : assert property (|(stat_r & enable_r) |=> irq)
      else $error("interrupt not raised");

   chk_irq_quiet : assert property (!(|(stat_r & enable_r)) |=> !irq)
      else $error("interrupt raised with no enabled flag");
endmodule

// ---- tb/tsf_pin_src.sv ----
// Far-side source for the timer input pin: steady level or noise
`timescale 1ns/10ps
module tsf_pin_src (
   // Clock
   input  wire logic clk,
   // Mode select
   input  wire logic noisy,
   input  wire logic level,
   // Pin
   output logic      pin
);
   int cnt;

   initial begin
      pin = 1'b0;
      cnt = 0;
   end

   // Runs of three survive any input agreement stage yet mix every window
   always @(posedge clk) begin
      cnt <= (cnt == 2) ? 0 : cnt + 1;
      if (noisy) begin
         if (cnt == 2) begin
            pin <= ~pin;
         end
      end else begin
         pin <= level;
      end
   end
endmodule

// ---- tb/test_timer_status_flags.sv ----
// Self-checking bench for the timer status flag block
`timescale 1ns/10ps
module test_timer_status_flags;
   import tsf_pkg::*;
   logic        clk, resetn, wr, rd, bit_centre, reload_event, noisy, level;
   logic        pin, filtered_input, irq;
   logic [11:0] addr;
   logic [7:0]  wdata, rdata, rv;
   logic [1:0]  chan_event;
   int          err_count, checks, seed, mdl, ena, r;

   tsf_status uut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .chan_event(chan_event), .reload_event(reload_event),
      .bit_centre(bit_centre), .timer_input_pin(pin), .filtered_input(filtered_input),
      .irq(irq));
   tsf_pin_src src (.clk(clk), .noisy(noisy), .level(level), .pin(pin));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic end_sim();
      if (err_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic pulse(input logic [1:0] ch, input logic rl, input logic bc);
      @(posedge clk);
      chan_event   <= ch;
      reload_event <= rl;
      bit_centre   <= bc;
      @(posedge clk);
      chan_event   <= 2'b00;
      reload_event <= 1'b0;
      bit_centre   <= 1'b0;
   endtask

   task automatic evt(input logic [1:0] ch, input logic rl);
      pulse(ch, rl, 1'b0);
      for (int i = 0; i < 2; i++) begin
         if (ch[i]) begin
            mdl[i + 4] = mdl[i + 4] | mdl[i];
            mdl[i] = 1'b1;
         end
      end
      mdl[3] = mdl[3] | rl;
   endtask

   // Overrun bits only fall with their event flag
   task automatic clr(input logic [11:0] a, input logic [7:0] m);
      wr_reg(a, m);
      for (int i = 0; i < 2; i++) begin
         if (m[i]) begin
            mdl[i] = 1'b0;
            mdl[i + 4] = 1'b0;
         end
      end
      mdl = mdl & ~int'(m & 8'h88);
   endtask

   task automatic cmp();
      rd_reg(TSF_ADDR_STATUS, rv);
      chk(rv, mdl[7:0]);
      chk({7'h00, irq}, {7'h00, |(mdl[7:0] & ena[7:0])});
   endtask

   initial begin
      #100000;
      err_count++;
      end_sim();
   end

   initial begin
      seed = 32'hB016;
      {resetn, wr, rd, bit_centre, reload_event, noisy, level} = 7'h00;
      addr = 12'h000;
      wdata = 8'h00;
      chan_event = 2'b00;
      err_count = 0;
      checks = 0;
      mdl = 0;
      ena = 0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      cmp();
      evt(2'b11, 1'b1);
      evt(2'b11, 1'b0);
      cmp();
      @(posedge clk);
      #1 chk(rdata, 8'h00);
      clr(TSF_ADDR_STATUS, 8'h74);
      cmp();
      clr(TSF_ADDR_CLEAR, 8'h01);
      cmp();
      rd_reg(12'h100, rv);
      chk(rv, 8'h00);
      @(posedge clk);
      #1 chk(rdata, 8'h00);
      for (int n = 0; n < 24; n++) begin
         ena = $random(seed);
         wr_reg(TSF_ADDR_ENABLE, ena[7:0]);
         ena = ena & 8'hBB;
         rd_reg(TSF_ADDR_ENABLE, rv);
         chk(rv, ena[7:0]);
         r = $random(seed);
         evt(r[1:0], r[2]);
         cmp();
         clr(r[3] ? TSF_ADDR_CLEAR : TSF_ADDR_STATUS, r[15:8]);
         cmp();
      end
      // Event and clear in one cycle: the set wins, overrun drops
      evt(2'b01, 1'b1);
      evt(2'b01, 1'b0);
      @(posedge clk);
      addr         <= TSF_ADDR_CLEAR;
      wdata        <= 8'h89;
      wr           <= 1'b1;
      chan_event   <= 2'b01;
      reload_event <= 1'b1;
      @(posedge clk);
      wr           <= 1'b0;
      chan_event   <= 2'b00;
      reload_event <= 1'b0;
      mdl = (mdl & ~32'h99) | 32'h09;
      cmp();
      // Noisy pin with the filter off must set no noise flag
      wr_reg(TSF_ADDR_CTRL, 8'h00);
      noisy <= 1'b1;
      repeat (10) @(posedge clk);
      pulse(2'b00, 1'b0, 1'b1);
      repeat (4) @(posedge clk);
      cmp();
      wr_reg(TSF_ADDR_CTRL, 8'h80);
      rd_reg(TSF_ADDR_CTRL, rv);
      chk(rv, 8'h80);
      repeat (10) @(posedge clk);
      pulse(2'b00, 1'b0, 1'b1);
      mdl[7] = 1'b1;
      repeat (4) @(posedge clk);
      cmp();
      @(posedge clk);
      noisy <= 1'b0;
      level <= 1'b1;
      repeat (16) @(posedge clk);
      // Filtered value takes the steady high level at a bit centre
      clr(TSF_ADDR_STATUS, 8'h80);
      pulse(2'b00, 1'b0, 1'b1);
      repeat (4) @(posedge clk);
      cmp();
      chk({7'h00, filtered_input}, 8'h01);
      // Reset again mid-run: flags and enables drop
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      mdl = 0;
      ena = 0;
      cmp();
      evt(2'b10, 1'b0);
      cmp();
      end_sim();
   end
endmodule
